//--- dv/odtpd_ctrl_props.sv
// Checker on odtpd_ctrl ports.
// Assumes CWL 5, AL 0, refresh and exit counts of 4.
`timescale 1ns/1ps
`default_nettype none
module odtpd_ctrl_props (
	// Inputs and outputs watched
	input wire SYS_CLK_I, RSTN_I, MR0_DLL_PPD_I, CKE_I, ODT_I, BANKS_IDLE_I,
	input wire RTT_EN_O, ASYNC_MODE_O, ENTRY_WIN_O, EXIT_WIN_O,
	input wire [4:0] CWL_I, AL_I, TANPD_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RSTN_I);
	property p_tanpd; TANPD_O != 5'h00 |-> TANPD_O == CWL_I + AL_I - 5'h01; endproperty
	a_tanpd: assert property (p_tanpd) else $error("tanpd");
	property p_async; ASYNC_MODE_O |-> RTT_EN_O == $past(ODT_I); endproperty
	a_async: assert property (p_async) else $error("async rtt");
	property p_refuse; MR0_DLL_PPD_I && !ASYNC_MODE_O |=> !ASYNC_MODE_O; endproperty
	a_refuse: assert property (p_refuse) else $error("refuse");
	property p_idle; !BANKS_IDLE_I && !ASYNC_MODE_O |=> !ASYNC_MODE_O; endproperty
	a_idle: assert property (p_idle) else $error("idle refuse");
	property p_entry; $fell(CKE_I) && !MR0_DLL_PPD_I && BANKS_IDLE_I |=> ASYNC_MODE_O; endproperty
	a_entry: assert property (p_entry) else $error("entry");
	property p_exit; $rose(CKE_I) && ASYNC_MODE_O && !ENTRY_WIN_O |=> EXIT_WIN_O; endproperty
	a_exit: assert property (p_exit) else $error("exit");
	// Full exit window of four cycles, then synchronous again
	property p_xlen; $rose(EXIT_WIN_O) ##1 EXIT_WIN_O [*3] |=> !ASYNC_MODE_O; endproperty
	a_xlen: assert property (p_xlen) else $error("exit len");
	property p_elen; $rose(ENTRY_WIN_O) |-> ##[1:4] !ENTRY_WIN_O; endproperty
	a_elen: assert property (p_elen) else $error("entry len");
	// Latency three plus the output register
	property p_sync; !ASYNC_MODE_O [*4] |-> RTT_EN_O == $past(ODT_I, 4); endproperty
	a_sync: assert property (p_sync) else $error("sync rtt");
	c_entry: cover property ($rose(ENTRY_WIN_O));
	c_exit: cover property ($rose(EXIT_WIN_O));
	c_on: cover property (ASYNC_MODE_O && RTT_EN_O);
	c_short: cover property (EXIT_WIN_O ##1 (ASYNC_MODE_O && !EXIT_WIN_O));
endmodule
bind odtpd_ctrl odtpd_ctrl_props odtpd_ctrl_props_inst (.*);
`default_nettype wire

//--- dv/odtpd_ctrl_tb_top.sv
// Self-checking bench for odtpd_ctrl.
// Assumes the controller model and counts shortened to 4.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fails++; \
	$display("[ERR] %s exp %0h got %0h", n, e, a); end end
module odtpd_ctrl_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic dll = 1'b0;
	logic idle = 1'b1;
	logic [4:0] cwl = 5'h05;
	logic [4:0] al = 5'h00;
	wire cke, odt, rfc, rtt, asy, ent, ext;
	wire [4:0] tanpd;
	int fails = 0;
	int tests_run = 0;
	int cyc = 0;
	initial forever #2.5 clk = ~clk;
	odtpd_mc_model odtpd_mc_model_inst (.clk_i(clk), .cke_o(cke), .odt_o(odt), .ref_o(rfc));
	odtpd_ctrl #(.TRFC_CYC(16'h0004), .TXPDLL_CYC(16'h0004)) odtpd_ctrl_inst (
		.SYS_CLK_I(clk), .RSTN_I(rst_n), .MR0_DLL_PPD_I(dll), .CWL_I(cwl), .AL_I(al),
		.CKE_I(cke), .ODT_I(odt), .REF_CMD_I(rfc), .BANKS_IDLE_I(idle), .RTT_EN_O(rtt),
		.ASYNC_MODE_O(asy), .ENTRY_WIN_O(ent), .EXIT_WIN_O(ext), .TANPD_O(tanpd));
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic d(input logic c, input logic o, input logic r);
		odtpd_mc_model_inst.drv(c, o, r);
	endtask
	task automatic t_sync;
		d(1'b1, 1'b1, 1'b0);
		w(3);
		`CHK("rtt early", 1'b0, rtt)
		w(1);
		`CHK("rtt sync", 1'b1, rtt)
		`CHK("tanpd", cwl + al - 5'h01, tanpd)
		d(1'b1, 1'b0, 1'b0);
		w(4);
	endtask
	task automatic t_pd;
		d(1'b0, 1'b0, 1'b0);
		w(1);
		`CHK("async", 1'b1, asy)
		d(1'b0, 1'b1, 1'b0);
		w(1);
		`CHK("rtt on", 1'b1, rtt)
		d(1'b0, 1'b0, 1'b0);
		w(1);
		`CHK("rtt off", 1'b0, rtt)
		d(1'b1, 1'b0, 1'b0);
		w(1);
		`CHK("exit win", 1'b1, ext)
		w(6);
		`CHK("sync back", 1'b0, asy)
	endtask
	task automatic t_ref;
		d(1'b1, 1'b0, 1'b1);
		d(1'b0, 1'b0, 1'b0);
		w(1);
		`CHK("entry win", 1'b1, ent)
		w(4);
		`CHK("entry end", 1'b0, ent)
		d(1'b1, 1'b0, 1'b0);
		w(8);
	endtask
	// Short CKE low inside a refresh, then short CKE high in exit
	task automatic t_short;
		d(1'b1, 1'b0, 1'b1);
		d(1'b0, 1'b0, 1'b0);
		d(1'b1, 1'b0, 1'b0);
		w(1);
		`CHK("short low entry", 1'b1, ent)
		w(2);
		`CHK("short low exit", 1'b1, ext)
		d(1'b0, 1'b0, 1'b0);
		w(1);
		`CHK("short high async", 1'b1, asy)
		`CHK("short high no exit", 1'b0, ext)
		d(1'b1, 1'b0, 1'b0);
		w(1);
		`CHK("short exit again", 1'b1, ext)
		w(5);
		`CHK("short sync back", 1'b0, asy)
	endtask
	task automatic t_refuse;
		@(posedge clk) dll <= 1'b1;
		d(1'b0, 1'b0, 1'b0);
		w(1);
		`CHK("refused", 1'b0, asy)
		d(1'b1, 1'b0, 1'b0);
		w(2);
		@(posedge clk);
		dll <= 1'b0;
		idle <= 1'b0;
		d(1'b0, 1'b0, 1'b0);
		w(1);
		`CHK("active pd refused", 1'b0, asy)
		d(1'b1, 1'b0, 1'b0);
		w(2);
	endtask
	task automatic report_and_stop;
		if (fails == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 400) begin
			fails++;
			report_and_stop;
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		w(3);
		t_sync;
		t_pd;
		t_ref;
		t_short;
		t_refuse;
		report_and_stop;
	end
endmodule
`default_nettype wire

//--- dv/odtpd_mc_model.sv
// Memory controller model driving CKE, ODT and refresh.
// Assumes one drv call per transfer.
`timescale 1ns/1ps
`default_nettype none
module odtpd_mc_model (
	// Pins
	input wire clk_i,
	output logic cke_o = 1'b1,
	output logic odt_o = 1'b0,
	output logic ref_o = 1'b0
);
	task automatic drv(input logic c, input logic o, input logic r);
		@(posedge clk_i);
		cke_o <= c;
		odt_o <= o;
		ref_o <= r;
	endtask
endmodule
`default_nettype wire

//--- shared/odtpd_defines.vh
// Constants for the ODT power-down transition controller.
// Assumes a 200 MHz core clock; times in ps, counts in cycles.
`ifndef ODTPD_DEFINES_VH
`define ODTPD_DEFINES_VH

`define ODTPD_CLK_PERIOD_PS 5000
// Asynchronous turn-on/turn-off delay bounds
`define ODTPD_TAONPD_MIN_PS 2000
`define ODTPD_TAONPD_MAX_PS 8500
// Least time rounds up, longest rounds down, never below one cycle
`define ODTPD_ASYNC_MIN_CYC (((`ODTPD_TAONPD_MIN_PS + `ODTPD_CLK_PERIOD_PS - 1) / `ODTPD_CLK_PERIOD_PS) < 1 ? 1 : ((`ODTPD_TAONPD_MIN_PS + `ODTPD_CLK_PERIOD_PS - 1) / `ODTPD_CLK_PERIOD_PS))
`define ODTPD_ASYNC_MAX_CYC ((`ODTPD_TAONPD_MAX_PS / `ODTPD_CLK_PERIOD_PS) < 1 ? 1 : (`ODTPD_TAONPD_MAX_PS / `ODTPD_CLK_PERIOD_PS))
// Offset of latencies from write latency
`define ODTPD_ODTL_OFFSET 5'h02
`define ODTPD_ANPD_OFFSET 5'h01
// Default refresh and DLL-off exit times in cycles
`define ODTPD_TRFC_CYC 16'h0040
`define ODTPD_TXPDLL_CYC 16'h0018
// Reset values
`define ODTPD_ZERO5 5'h00

`endif

//--- src/odtpd_ctrl.v
// ODT controller covering synchronous/asynchronous transitions
// around precharge power-down with the DLL switched off.
// Assumes CKE, ODT and commands synchronous to SYS_CLK_I, mode values static.
`timescale 1ns/1ps
`default_nettype none
`include "odtpd_defines.vh"

module odtpd_ctrl #(
	parameter DEPTH = 32,
	parameter CW = 16,
	parameter [CW-1:0] TRFC_CYC = `ODTPD_TRFC_CYC,
	parameter [CW-1:0] TXPDLL_CYC = `ODTPD_TXPDLL_CYC
) (
	// Clock and reset
	input wire SYS_CLK_I,
	input wire RSTN_I,
	// Mode settings
	input wire MR0_DLL_PPD_I,
	input wire [4:0] CWL_I,
	input wire [4:0] AL_I,
	// Memory controller pins and decoded commands
	input wire CKE_I,
	input wire ODT_I,
	input wire REF_CMD_I,
	input wire BANKS_IDLE_I,
	// Termination and status
	output reg RTT_EN_O,
	output reg ASYNC_MODE_O,
	output reg ENTRY_WIN_O,
	output reg EXIT_WIN_O,
	output reg [4:0] TANPD_O
);

	localparam [3:0] ST_SYNC = 4'b0001;
	localparam [3:0] ST_ENTRY = 4'b0010;
	localparam [3:0] ST_ASYNC = 4'b0100;
	localparam [3:0] ST_EXIT = 4'b1000;

	reg rst_meta_q;
	reg rst_sync_q;
	reg [3:0] state_q;
	reg [3:0] state_d;
	reg cke_q;
	reg [CW-1:0] rfc_cnt_q;
	reg [CW-1:0] rfc_cnt_d;
	reg [CW-1:0] xp_cnt_q;
	reg [CW-1:0] xp_cnt_d;
	reg [4:0] odtl_q;
	reg rtt_d;
	wire sync_tap;
	wire cke_fell;
	wire cke_rose;
	wire dll_off_pd;

	// Latency minus offset, held at least one
	function [4:0] lat_sub;
		input [4:0] cwl;
		input [4:0] al;
		input [4:0] off;
		reg [5:0] sum;
		begin
			sum = {1'b0, cwl} + {1'b0, al};
			if (sum <= {1'b0, off}) begin
				lat_sub = 5'h01;
			end else begin
				lat_sub = sum[4:0] - off;
			end
		end
	endfunction

	// Reset release through two flops
	always @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	odtpd_lat_line #(
		.DEPTH(DEPTH),
		.SELW(5)
	) u_lat (
		.clk_i(SYS_CLK_I),
		.rst_n_i(rst_sync_q),
		.odt_i(ODT_I),
		.sel_i(odtl_q - 5'h01),
		.tap_o(sync_tap)
	);

	assign cke_fell = cke_q && !CKE_I;
	assign cke_rose = !cke_q && CKE_I;
	// only precharge power-down with DLL off
	assign dll_off_pd = !MR0_DLL_PPD_I && BANKS_IDLE_I;

	always @* begin
		state_d = state_q;
		rfc_cnt_d = rfc_cnt_q;
		xp_cnt_d = xp_cnt_q;
		// refresh time tracked from the command
		if (REF_CMD_I) begin
			rfc_cnt_d = TRFC_CYC;
		end else if (rfc_cnt_q != {CW{1'b0}}) begin
			rfc_cnt_d = rfc_cnt_q - {{(CW-1){1'b0}}, 1'b1};
		end
		case (state_q)
			ST_SYNC: begin
				// entry window starts at first CKE low while a refresh runs
				if (cke_fell && dll_off_pd) begin
					if (rfc_cnt_q > {{(CW-1){1'b0}}, 1'b1}) begin
						state_d = ST_ENTRY;
					end else begin
						state_d = ST_ASYNC;
					end
				end
			end
			ST_ENTRY: begin
				// extended end; early exit keeps window open
				if (rfc_cnt_q <= {{(CW-1){1'b0}}, 1'b1}) begin
					if (CKE_I) begin
						state_d = ST_EXIT;
						xp_cnt_d = TXPDLL_CYC;
					end else begin
						state_d = ST_ASYNC;
					end
				end
			end
			ST_ASYNC: begin
				// exit window runs tXPDLL after first CKE high
				if (cke_rose) begin
					state_d = ST_EXIT;
					xp_cnt_d = TXPDLL_CYC;
				end
			end
			ST_EXIT: begin
				if (cke_fell && dll_off_pd) begin
					state_d = ST_ASYNC;
				end else if (xp_cnt_q <= {{(CW-1){1'b0}}, 1'b1}) begin
					state_d = ST_SYNC;
					xp_cnt_d = {CW{1'b0}};
				end else begin
					xp_cnt_d = xp_cnt_q - {{(CW-1){1'b0}}, 1'b1};
				end
			end
			default: begin
				state_d = ST_SYNC;
			end
		endcase
	end

	always @* begin
		case (state_d)
			// asynchronous: no AL, one-cycle delay within bounds
			ST_ASYNC: rtt_d = ODT_I;
			ST_ENTRY: rtt_d = ODT_I;
			ST_EXIT: rtt_d = ODT_I;
			default: rtt_d = sync_tap;
		endcase
	end

	always @(posedge SYS_CLK_I or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			state_q <= ST_SYNC;
			cke_q <= 1'b0;
			rfc_cnt_q <= {CW{1'b0}};
			xp_cnt_q <= {CW{1'b0}};
			odtl_q <= 5'h01;
			RTT_EN_O <= 1'b0;
			ASYNC_MODE_O <= 1'b0;
			ENTRY_WIN_O <= 1'b0;
			EXIT_WIN_O <= 1'b0;
			TANPD_O <= `ODTPD_ZERO5;
		end else begin
			state_q <= state_d;
			cke_q <= CKE_I;
			rfc_cnt_q <= rfc_cnt_d;
			xp_cnt_q <= xp_cnt_d;
			odtl_q <= lat_sub(CWL_I, AL_I, `ODTPD_ODTL_OFFSET);
			RTT_EN_O <= rtt_d;
			ASYNC_MODE_O <= (state_d != ST_SYNC);
			ENTRY_WIN_O <= (state_d == ST_ENTRY);
			EXIT_WIN_O <= (state_d == ST_EXIT);
			// tANPD as write latency minus one
			TANPD_O <= lat_sub(CWL_I, AL_I, `ODTPD_ANPD_OFFSET);
		end
	end

endmodule

`default_nettype wire

//--- src/odtpd_lat_line.v
// Clock-counted ODT latency line with a selectable tap.
// Assumes tap select stable while used; one clock domain.
`timescale 1ns/1ps
`default_nettype none

module odtpd_lat_line #(
	parameter DEPTH = 32,
	parameter SELW = 5
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_n_i,
	// Data
	input wire odt_i,
	input wire [SELW-1:0] sel_i,
	output wire tap_o
);

	reg [DEPTH-1:0] line_q;

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			line_q <= {DEPTH{1'b0}};
		end else begin
			line_q <= {line_q[DEPTH-2:0], odt_i};
		end
	end

	// Tap i holds the sample taken i+1 edges ago
	assign tap_o = line_q[sel_i];

endmodule

`default_nettype wire
